//--- dhtr_pkg.sv
// Shared constants and types for the dual half timer with clock mode,
// plus the pin synchroniser used on the capture pin.
// Assumes one system clock and an asynchronous active-low reset.
//
// Behaviour
// - Reset: unit idle, counters and loads 0xFFFF, prescale values zero.
// - Width config 0 gives joined 32-bit timer, 1 gives joined clock mode.
// - Width config 0x4 gives two independent 16-bit halves.
// - Joined modes: 32-bit first-half load write fills both half loads.
// - Joined modes: first-half count read returns second:first halves; reads 0x0000FFFF from reset until the first clock.
// - Joined timer counts down as one; first-half mode field alone chooses.
// - Run bit starts countdown; after zero the joined load reloads next cycle.
// - One-shot stops and clears its run bit; periodic keeps counting.
// - Zero sets sticky raw timeout flag; masked flag when mask bit set.
// - Each timeout pulses the trigger output when trigger enable is set.
// - Load write while running takes effect on the next clock; in clock mode the count ignores it.
// - Freeze bit holds the count; counting resumes when it clears.
// - Clock mode counts up; first selection loads the counter with one.
// - Capture pin clock divided down to one tick per second advances count.
// - Count equal to compare wraps to zero, sets raw match flag; masked flag when mask bit set.
// - Clock mode override bit disables the freeze bits in clock mode.
// - 16-bit mode: each half counts down, own mode field picks type.
// - Prescale P makes each 16-bit step last P+1 clocks; the reload at zero takes one clock.
// - Mode field: 0x1 one-shot, 0x2 periodic.
// - Writing one to a clear bit clears raw and masked flag.

package dhtr_pkg;

  localparam int unsigned HALF_W  = 16;
  localparam int unsigned FULL_W  = 32;
  localparam int unsigned PRE_W   = 8;
  localparam int unsigned FLAG_W  = 3;

  // Write select codes for the software write strobe
  typedef enum logic [2:0] {
    SEL_CFG    = 3'h0,
    SEL_CTL    = 3'h1,
    SEL_LOAD_A = 3'h2,
    SEL_LOAD_B = 3'h3,
    SEL_PRE_A  = 3'h4,
    SEL_PRE_B  = 3'h5,
    SEL_MATCH  = 3'h6,
    SEL_CLEAR  = 3'h7
  } dhtr_sel_t;

  typedef enum logic [2:0] {
    WM_JOIN_TIMER = 3'h0,
    WM_JOIN_CLOCK = 3'h1,
    WM_SPLIT      = 3'h4
  } dhtr_wmode_t;

  typedef enum logic [1:0] {
    HM_NONE     = 2'h0,
    HM_ONESHOT  = 2'h1,
    HM_PERIODIC = 2'h2,
    HM_RSVD     = 2'h3
  } dhtr_hmode_t;

  // Control write bit positions
  localparam int unsigned CTL_RUN_A = 0;
  localparam int unsigned CTL_RUN_B = 1;

  // Flag bit positions in raw, masked and clear words
  localparam int unsigned FLG_TO_A  = 0;
  localparam int unsigned FLG_TO_B  = 1;
  localparam int unsigned FLG_CLK   = 2;

  localparam logic [HALF_W-1:0] CNT_RST   = 16'hFFFF;
  localparam logic [PRE_W-1:0]  PRE_RST   = 8'h00;
  localparam logic [FULL_W-1:0] MATCH_RST = 32'hFFFFFFFF;
  localparam logic [FULL_W-1:0] CLK_FIRST = 32'h00000001;
  localparam logic [FULL_W-1:0] ZERO32    = 32'h00000000;
  localparam logic [HALF_W-1:0] ZERO16    = 16'h0000;

  // Capture pin clock and the tick rate it is divided down to
  localparam int unsigned CLK_IN_HZ   = 32768;
  localparam int unsigned CLK_TICK_HZ = 1;
  localparam int unsigned CLK_DIV_DEF = CLK_IN_HZ / CLK_TICK_HZ;

endpackage : dhtr_pkg

`timescale 1ns/1ps

// Two-flop synchroniser with a rising-edge pulse taken after the second flop
module dhtr_sync (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic pin_in,
  output logic      rise_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign rise_out = s2_r & ~s3_r;

endmodule : dhtr_sync

//--- dhtr_prescale.sv
// Per-half prescaler: issues one step enable every P+1 clocks while running.
// Assumes the caller reloads it whenever the half reloads its count.

`timescale 1ns/1ps

module dhtr_prescale #(
  parameter int unsigned PRE_W = 8
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             run_in,
  input  wire logic             reload_in,
  input  wire logic [PRE_W-1:0] value_in,
  output logic                  step_out
);
  logic [PRE_W-1:0] pcnt_r;
  logic [PRE_W-1:0] pcnt_nxt;
  logic             at_end;

  assign at_end   = (pcnt_r == '0);
  assign step_out = run_in & at_end & ~reload_in;
  assign pcnt_nxt = reload_in ? value_in :
                    step_out  ? value_in :
                    run_in    ? pcnt_r - 1'b1 : pcnt_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pcnt_r <= '0;
    end else begin
      pcnt_r <= pcnt_nxt;
    end
  end

endmodule : dhtr_prescale

//--- dhtr_top.sv
// Dual half timer: joined 32-bit one-shot/periodic timer, joined clock
// mode driven from the capture pin, or two 16-bit timers with prescalers.
// Software access is a write strobe with a select code; configuration
// levels (modes, mask, freeze, trigger enables) are plain inputs from
// logic on the same clock. The capture pin is asynchronous.

`timescale 1ns/1ps

module dhtr_top
  import dhtr_pkg::*;
#(
  parameter int unsigned CLK_DIV = dhtr_pkg::CLK_DIV_DEF
) (
  input  wire logic                      clk_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      wr_in,
  input  wire dhtr_pkg::dhtr_sel_t       wr_sel_in,
  input  wire logic [31:0]               wr_data_in,
  input  wire dhtr_pkg::dhtr_hmode_t     first_half_mode_field_in,
  input  wire dhtr_pkg::dhtr_hmode_t     second_half_mode_field_in,
  input  wire logic [2:0]                flag_mask_in,
  input  wire logic                      first_half_trigger_out_en_in,
  input  wire logic                      second_half_trigger_out_en_in,
  input  wire logic                      first_half_freeze_bit_in,
  input  wire logic                      second_half_freeze_bit_in,
  input  wire logic                      clock_mode_freeze_override_in,
  input  wire logic                      capture_pin_in,
  output logic [31:0]                    first_half_count_out,
  output logic [15:0]                    second_half_count_out,
  output logic                           first_half_run_out,
  output logic                           second_half_run_out,
  output logic [2:0]                     raw_flag_out,
  output logic [2:0]                     masked_flag_out,
  output logic                           irq_out,
  output logic                           first_half_trigger_out,
  output logic                           second_half_trigger_out
);
  import dhtr_pkg::*;

  localparam int unsigned DIV_W = (CLK_DIV > 1) ? $clog2(CLK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);

  function automatic logic f_mode_ok(input dhtr_hmode_t m);
    f_mode_ok = (m == HM_ONESHOT) || (m == HM_PERIODIC);
  endfunction : f_mode_ok

  function automatic logic f_oneshot(input dhtr_hmode_t m);
    f_oneshot = (m == HM_ONESHOT);
  endfunction : f_oneshot

  // State
  dhtr_wmode_t        cfg_r;
  logic               run_a_r;
  logic               run_b_r;
  logic [HALF_W-1:0]  load_a_r;
  logic [HALF_W-1:0]  load_b_r;
  logic [HALF_W-1:0]  cnt_a_r;
  logic [HALF_W-1:0]  cnt_b_r;
  logic [PRE_W-1:0]   pre_a_r;
  logic [PRE_W-1:0]   pre_b_r;
  logic [FULL_W-1:0]  match_r;
  logic [FLAG_W-1:0]  raw_r;
  logic [FLAG_W-1:0]  masked_r;
  logic               irq_r;
  logic               trig_a_r;
  logic               trig_b_r;
  logic [FULL_W-1:0]  rd_a_r;
  logic [HALF_W-1:0]  rd_b_r;
  logic [DIV_W-1:0]   div_r;

  // Next values
  dhtr_wmode_t        cfg_nxt;
  logic               run_a_nxt;
  logic               run_b_nxt;
  logic [HALF_W-1:0]  load_a_nxt;
  logic [HALF_W-1:0]  load_b_nxt;
  logic [HALF_W-1:0]  cnt_a_nxt;
  logic [HALF_W-1:0]  cnt_b_nxt;
  logic [FULL_W-1:0]  cnt32_nxt;
  logic [FLAG_W-1:0]  raw_nxt;
  logic [FLAG_W-1:0]  masked_nxt;
  logic [DIV_W-1:0]   div_nxt;

  // Write decode
  wire wr_cfg    = wr_in && (wr_sel_in == SEL_CFG);
  wire wr_ctl    = wr_in && (wr_sel_in == SEL_CTL);
  wire wr_load_a = wr_in && (wr_sel_in == SEL_LOAD_A);
  wire wr_load_b = wr_in && (wr_sel_in == SEL_LOAD_B);
  wire wr_pre_a  = wr_in && (wr_sel_in == SEL_PRE_A);
  wire wr_pre_b  = wr_in && (wr_sel_in == SEL_PRE_B);
  wire wr_match  = wr_in && (wr_sel_in == SEL_MATCH);
  wire wr_clear  = wr_in && (wr_sel_in == SEL_CLEAR);

  // Mode decode
  wire is_join_tmr = (cfg_r == WM_JOIN_TIMER);
  wire is_join_clk = (cfg_r == WM_JOIN_CLOCK);
  wire is_split    = (cfg_r == WM_SPLIT);
  wire is_joined   = is_join_tmr | is_join_clk;

  wire [FULL_W-1:0] cnt32  = {cnt_b_r, cnt_a_r};
  wire [FULL_W-1:0] load32 = {load_b_r, load_a_r};

  wire mode_ok_a = f_mode_ok(first_half_mode_field_in);
  wire mode_ok_b = f_mode_ok(second_half_mode_field_in);
  wire os_a      = f_oneshot(first_half_mode_field_in);
  wire os_b      = f_oneshot(second_half_mode_field_in);

  // Entering clock mode from any other width loads the count with one
  wire clk_first = wr_cfg && (wr_data_in[2:0] == WM_JOIN_CLOCK) &&
                   (cfg_r != WM_JOIN_CLOCK);

  // Joined timer: second-half mode is ignored
  wire act32  = is_join_tmr & run_a_r & mode_ok_a & ~first_half_freeze_bit_in;
  wire zero32 = act32 & (cnt32 == ZERO32);

  // Clock mode: freeze bits only bite while the override is clear
  wire clk_frozen = (first_half_freeze_bit_in | second_half_freeze_bit_in) &
                    ~clock_mode_freeze_override_in;
  wire clk_go     = is_join_clk & run_a_r & ~clk_frozen;

  logic pin_rise;

  dhtr_sync u_pin_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .pin_in    (capture_pin_in),
    .rise_out  (pin_rise)
  );

  wire clk_tick = clk_go & pin_rise & (div_r == DIV_LAST);
  wire clk_hit  = clk_tick & (cnt32 == match_r);

  // Split halves
  wire act_a16  = is_split & run_a_r & mode_ok_a & ~first_half_freeze_bit_in;
  wire act_b16  = is_split & run_b_r & mode_ok_b & ~second_half_freeze_bit_in;
  wire zero_a16 = act_a16 & (cnt_a_r == ZERO16);
  wire zero_b16 = act_b16 & (cnt_b_r == ZERO16);

  wire pre_rl_a = zero_a16 | wr_pre_a | wr_load_a | ~act_a16;
  wire pre_rl_b = zero_b16 | wr_pre_b | wr_load_b | ~act_b16;

  logic step_a;
  logic step_b;

  dhtr_prescale #(
    .PRE_W (PRE_W)
  ) u_pre_a (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .run_in    (act_a16),
    .reload_in (pre_rl_a),
    .value_in  (pre_a_r),
    .step_out  (step_a)
  );

  dhtr_prescale #(
    .PRE_W (PRE_W)
  ) u_pre_b (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .run_in    (act_b16),
    .reload_in (pre_rl_b),
    .value_in  (pre_b_r),
    .step_out  (step_b)
  );

  // Timeout events and one-shot stops
  wire to_a   = zero32 | zero_a16;
  wire to_b   = zero_b16;
  wire stop_a = (zero32 | zero_a16) & os_a;
  wire stop_b = zero_b16 & os_b;

  // Width config
  assign cfg_nxt = wr_cfg ? dhtr_wmode_t'(wr_data_in[2:0]) : cfg_r;

  // Run bits: a software write in the same cycle as a one-shot stop wins
  assign run_a_nxt = wr_ctl ? wr_data_in[CTL_RUN_A] :
                     stop_a ? 1'b0 : run_a_r;
  assign run_b_nxt = wr_ctl ? wr_data_in[CTL_RUN_B] :
                     stop_b ? 1'b0 : run_b_r;

  // Load registers; joined modes split a 32-bit write over both halves
  assign load_a_nxt = wr_load_a ? wr_data_in[15:0] : load_a_r;
  assign load_b_nxt = (wr_load_a && is_joined) ? wr_data_in[31:16] :
                      wr_load_b ? wr_data_in[15:0] : load_b_r;

  // Joined count
  always_comb begin
    cnt32_nxt = cnt32;
    if (clk_first) begin
      cnt32_nxt = CLK_FIRST;
    end else if (is_join_tmr) begin
      if (wr_load_a) begin
        cnt32_nxt = wr_data_in;
      end else if (zero32) begin
        cnt32_nxt = load32;
      end else if (act32) begin
        cnt32_nxt = cnt32 - 32'h00000001;
      end
    end else if (is_join_clk) begin
      if (clk_hit) begin
        cnt32_nxt = ZERO32;
      end else if (clk_tick) begin
        cnt32_nxt = cnt32 + 32'h00000001;
      end
    end
  end

  // Split counts
  always_comb begin
    cnt_a_nxt = cnt_a_r;
    cnt_b_nxt = cnt_b_r;
    if (is_joined || clk_first) begin
      cnt_a_nxt = cnt32_nxt[15:0];
      cnt_b_nxt = cnt32_nxt[31:16];
    end else if (is_split) begin
      if (wr_load_a) begin
        cnt_a_nxt = wr_data_in[15:0];
      end else if (zero_a16) begin
        cnt_a_nxt = load_a_r;
      end else if (step_a) begin
        cnt_a_nxt = cnt_a_r - 16'h0001;
      end
      if (wr_load_b) begin
        cnt_b_nxt = wr_data_in[15:0];
      end else if (zero_b16) begin
        cnt_b_nxt = load_b_r;
      end else if (step_b) begin
        cnt_b_nxt = cnt_b_r - 16'h0001;
      end
    end
  end

  // Pin edge divider; restarts on any width change
  always_comb begin
    div_nxt = div_r;
    if (wr_cfg) begin
      div_nxt = '0;
    end else if (clk_go && pin_rise) begin
      div_nxt = (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
    end
  end

  // Flags: a new event wins over a clear in the same cycle
  wire [FLAG_W-1:0] flag_set = {clk_hit, to_b, to_a};
  wire [FLAG_W-1:0] flag_clr = wr_clear ? wr_data_in[FLAG_W-1:0] : '0;

  assign raw_nxt    = flag_set | (raw_r & ~flag_clr);
  assign masked_nxt = raw_nxt & flag_mask_in;

  // Registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= WM_JOIN_TIMER;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_a_r <= 1'b0;
      run_b_r <= 1'b0;
    end else begin
      run_a_r <= run_a_nxt;
      run_b_r <= run_b_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      load_a_r <= CNT_RST;
      load_b_r <= CNT_RST;
      cnt_a_r  <= CNT_RST;
      cnt_b_r  <= CNT_RST;
    end else begin
      load_a_r <= load_a_nxt;
      load_b_r <= load_b_nxt;
      cnt_a_r  <= cnt_a_nxt;
      cnt_b_r  <= cnt_b_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_a_r <= PRE_RST;
      pre_b_r <= PRE_RST;
    end else begin
      if (wr_pre_a) begin
        pre_a_r <= wr_data_in[PRE_W-1:0];
      end
      if (wr_pre_b) begin
        pre_b_r <= wr_data_in[PRE_W-1:0];
      end
    end
  end

  // Compare value is the only way software moves the clock-mode wrap point
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      match_r <= MATCH_RST;
    end else if (wr_match) begin
      match_r <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      raw_r    <= '0;
      masked_r <= '0;
      irq_r    <= 1'b0;
    end else begin
      raw_r    <= raw_nxt;
      masked_r <= masked_nxt;
      irq_r    <= |masked_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trig_a_r <= 1'b0;
      trig_b_r <= 1'b0;
    end else begin
      trig_a_r <= to_a & first_half_trigger_out_en_in;
      trig_b_r <= to_b & second_half_trigger_out_en_in;
    end
  end

  // Read images track the count of the same edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_a_r <= {16'h0000, CNT_RST};
      rd_b_r <= CNT_RST;
    end else begin
      rd_a_r <= (cfg_nxt == WM_SPLIT) ? {ZERO16, cnt_a_nxt} :
                {cnt_b_nxt, cnt_a_nxt};
      rd_b_r <= cnt_b_nxt;
    end
  end

  assign first_half_count_out    = rd_a_r;
  assign second_half_count_out   = rd_b_r;
  assign first_half_run_out      = run_a_r;
  assign second_half_run_out     = run_b_r;
  assign raw_flag_out            = raw_r;
  assign masked_flag_out         = masked_r;
  assign irq_out                 = irq_r;
  assign first_half_trigger_out  = trig_a_r;
  assign second_half_trigger_out = trig_b_r;

endmodule : dhtr_top

//--- dhtr_top_checker.sv
// Port-level checker for the dual half timer top.
// Assumes it is bound to dhtr_top and sees only that module's ports.
`timescale 1ns/1ps
module dhtr_top_checker
  import dhtr_pkg::*;
#(
  parameter int unsigned CLK_DIV = 4
) (
  input wire logic                  clk_in,
  input wire logic                  arst_n_in,
  input wire logic                  wr_in,
  input wire dhtr_pkg::dhtr_sel_t   wr_sel_in,
  input wire logic [31:0]           wr_data_in,
  input wire dhtr_pkg::dhtr_hmode_t first_half_mode_field_in,
  input wire dhtr_pkg::dhtr_hmode_t second_half_mode_field_in,
  input wire logic [2:0]            flag_mask_in,
  input wire logic                  first_half_trigger_out_en_in,
  input wire logic                  second_half_trigger_out_en_in,
  input wire logic                  first_half_freeze_bit_in,
  input wire logic                  second_half_freeze_bit_in,
  input wire logic                  clock_mode_freeze_override_in,
  input wire logic                  capture_pin_in,
  input wire logic [31:0]           first_half_count_out,
  input wire logic [15:0]           second_half_count_out,
  input wire logic                  first_half_run_out,
  input wire logic                  second_half_run_out,
  input wire logic [2:0]            raw_flag_out,
  input wire logic [2:0]            masked_flag_out,
  input wire logic                  irq_out,
  input wire logic                  first_half_trigger_out,
  input wire logic                  second_half_trigger_out
);
  logic [2:0]  cfg_r;
  logic [31:0] ld_r;
  wire logic [2:0] clr_bits = (wr_in && wr_sel_in == SEL_CLEAR) ? wr_data_in[2:0] : 3'h0;
  wire logic mode_ok = first_half_mode_field_in == HM_ONESHOT
                    || first_half_mode_field_in == HM_PERIODIC;
  // Joined timer counting this cycle; writes excluded since they override the count
  wire logic jt_go = cfg_r == 3'h0 && first_half_run_out && mode_ok && !wr_in
                  && !first_half_freeze_bit_in;

  // Shadow of configuration and joined load value, as software wrote them
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= 3'h0;
      ld_r  <= 32'hFFFFFFFF;
    end else if (wr_in) begin
      if (wr_sel_in == SEL_CFG) cfg_r <= wr_data_in[2:0];
      if (wr_sel_in == SEL_LOAD_A) ld_r[15:0] <= wr_data_in[15:0];
      if (wr_sel_in == SEL_LOAD_A && cfg_r != 3'h4) ld_r[31:16] <= wr_data_in[31:16];
      if (wr_sel_in == SEL_LOAD_B) ld_r[31:16] <= wr_data_in[15:0];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_step;
    jt_go && first_half_count_out != ZERO32;
  endsequence
  sequence s_zero;
    jt_go && first_half_count_out == ZERO32;
  endsequence

  sequence s_clear_a;
    wr_in && wr_sel_in == SEL_CLEAR && wr_data_in[FLG_TO_A] && !first_half_run_out;
  endsequence
  // One-shot timeout pulse with no software write racing the hardware stop
  sequence s_os_fire;
    first_half_trigger_out && $past(first_half_mode_field_in) == HM_ONESHOT && !$past(wr_in);
  endsequence
  sequence s_frozen_a;
    first_half_freeze_bit_in && !clock_mode_freeze_override_in && !wr_in
      && first_half_count_out != ZERO32;
  endsequence

  chk_down_step: assert property (
    s_step |=> first_half_count_out == $past(first_half_count_out) - 32'h1)
    else $error("joined count did not step down by one");
  chk_zero_reload: assert property (
    s_zero |=> first_half_count_out == ld_r && raw_flag_out[FLG_TO_A])
    else $error("joined count did not reload at zero");
  chk_raw_sticky: assert property (
    (|($past(raw_flag_out) & ~raw_flag_out & ~$past(clr_bits))) == 1'b0)
    else $error("raw flag dropped without a clear write");
  chk_masked_in_raw: assert property ((masked_flag_out & ~raw_flag_out) == 3'h0)
    else $error("masked flag set without raw flag");
  chk_clear_both: assert property (
    s_clear_a |=> !raw_flag_out[FLG_TO_A] && !masked_flag_out[FLG_TO_A])
    else $error("clear write left timeout flag set");
  // Interrupt and masked flags are loaded on the same edge, so they agree every cycle
  chk_irq_or: assert property (irq_out == |masked_flag_out)
    else $error("interrupt output differs from masked flags");
  chk_trig_gate: assert property (
    first_half_trigger_out |-> $past(first_half_trigger_out_en_in) && raw_flag_out[FLG_TO_A])
    else $error("trigger without enable or timeout flag");
  chk_oneshot_stop: assert property (s_os_fire |-> !first_half_run_out)
    else $error("one-shot timer still running after timeout");
  chk_freeze_hold: assert property (s_frozen_a |=> $stable(first_half_count_out))
    else $error("frozen count changed");
endmodule : dhtr_top_checker

bind dhtr_top dhtr_top_checker #(.CLK_DIV(CLK_DIV)) dhtr_top_checker_i (.*);

//--- dhtr_top_test.sv
// Directed testbench for the dual half timer: joined, split and clock modes.
// Assumes the checker is bound by its own file; capture pin is slowed to 8 clocks.
`timescale 1ns/1ps
module dhtr_top_test;
  import dhtr_pkg::*;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        wr_in = 1'b0;
  dhtr_sel_t   wr_sel_in = SEL_CFG;
  logic [31:0] wr_data_in = 32'h0;
  dhtr_hmode_t first_half_mode_field_in = HM_ONESHOT;
  dhtr_hmode_t second_half_mode_field_in = HM_NONE;
  logic [2:0]  flag_mask_in = 3'h0;
  logic        first_half_trigger_out_en_in = 1'b0, second_half_trigger_out_en_in = 1'b0;
  logic        first_half_freeze_bit_in = 1'b0, second_half_freeze_bit_in = 1'b0;
  logic        clock_mode_freeze_override_in = 1'b0, capture_pin_in = 1'b0;
  logic [31:0] first_half_count_out;
  logic [15:0] second_half_count_out;
  logic        first_half_run_out, second_half_run_out, irq_out;
  logic [2:0]  raw_flag_out, masked_flag_out;
  logic        first_half_trigger_out, second_half_trigger_out;
  int          mismatches = 0, checks = 0, k = 0, trg_cnt = 0;
  logic [31:0] keep;
  wire logic [2:0] ev = {raw_flag_out[0], second_half_trigger_out, first_half_trigger_out};

  dhtr_top #(.CLK_DIV(4)) dhtr_top_i (.*);

  initial forever #4 clk_in = ~clk_in;
  always @(negedge clk_in) if (first_half_trigger_out === 1'b1) trg_cnt++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input dhtr_sel_t s, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    wr_sel_in <= s;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : cyc

  // Counts cycles up to the next pulse of the chosen event, bounded
  task automatic wait_ev(input int i);
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (ev[i] !== 1'b1 && k < 400);
    check("event wait", k < 400, 1'b1);
  endtask : wait_ev

  task automatic pins(input int n);
    repeat (n) begin
      @(posedge clk_in);
      capture_pin_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      capture_pin_in <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    cyc(6);
  endtask : pins

  task automatic close_out();
    if (mismatches == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    #200000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    cyc(0);
    check("count a", first_half_count_out, 32'h0000FFFF);
    check("count b", second_half_count_out, 32'h0000FFFF);
    check("status", {first_half_run_out, raw_flag_out, masked_flag_out, irq_out}, 32'h0);
    wr(SEL_LOAD_A, 32'h00010005);
    cyc(0);
    check("joined count", first_half_count_out, 32'h00010005);
    check("half b count", second_half_count_out, 32'h00000001);
    wr(SEL_LOAD_A, 32'h00000003);
    flag_mask_in <= 3'h7;
    first_half_trigger_out_en_in <= 1'b1;
    wr(SEL_CTL, 32'h1);
    wait_ev(0);
    check("reload", first_half_count_out, 32'h00000003);
    check("one shot", {first_half_run_out, raw_flag_out[0], masked_flag_out[0]}, 32'h3);
    cyc(1);
    check("irq and pulse", {irq_out, first_half_trigger_out}, 32'h2);
    cyc(3);
    check("stopped", first_half_count_out, 32'h00000003);
    wr(SEL_CLEAR, 32'h1);
    cyc(1);
    check("cleared", {raw_flag_out, masked_flag_out, irq_out}, 32'h0);
    @(posedge clk_in);
    first_half_mode_field_in <= HM_PERIODIC;
    first_half_trigger_out_en_in <= 1'b0;
    flag_mask_in <= 3'h0;
    wr(SEL_CTL, 32'h1);
    wait_ev(2);
    wr(SEL_CLEAR, 32'h1);
    wait_ev(2);
    check("periodic", {first_half_run_out, masked_flag_out, irq_out}, 32'h10);
    check("trigger gated", trg_cnt, 32'h1);
    wr(SEL_LOAD_A, 32'h00000100);
    cyc(0);
    check("load on the fly", first_half_count_out, 32'h00000100);
    cyc(2);
    check("count on", first_half_count_out, 32'h000000FE);
    @(posedge clk_in);
    first_half_freeze_bit_in <= 1'b1;
    cyc(1);
    keep = first_half_count_out;
    cyc(4);
    check("frozen", first_half_count_out, keep);
    @(posedge clk_in);
    first_half_freeze_bit_in <= 1'b0;
    cyc(1);
    check("resumed", first_half_count_out, keep - 32'h1);
    wr(SEL_CTL, 32'h0);
    wr(SEL_CFG, 32'h4);
    wr(SEL_LOAD_A, 32'h00000003);
    wr(SEL_PRE_A, 32'h00000002);
    wr(SEL_LOAD_B, 32'h00000005);
    second_half_mode_field_in <= HM_PERIODIC;
    first_half_trigger_out_en_in <= 1'b1;
    second_half_trigger_out_en_in <= 1'b1;
    wr(SEL_CTL, 32'h3);
    wait_ev(0);
    wait_ev(0);
    check("prescaled period", k, 32'd10);
    wait_ev(1);
    wait_ev(1);
    check("half b period", k, 32'd6);
    check("split upper", first_half_count_out[31:16], 32'h0);
    check("split flags", raw_flag_out[1:0], 32'h3);
    check("split runs", {first_half_run_out, second_half_run_out}, 32'h3);
    wr(SEL_CTL, 32'h0);
    flag_mask_in <= 3'h4;
    wr(SEL_CFG, 32'h1);
    cyc(0);
    check("clock first load", first_half_count_out, 32'h00000001);
    wr(SEL_MATCH, 32'h00000002);
    wr(SEL_CTL, 32'h1);
    pins(4);
    check("clock up", first_half_count_out, 32'h00000002);
    wr(SEL_LOAD_A, 32'h00000050);
    cyc(0);
    check("load ignored", first_half_count_out, 32'h00000002);
    pins(4);
    check("clock wrap", first_half_count_out, 32'h0);
    check("clock flags", {raw_flag_out[2], masked_flag_out[2], irq_out}, 32'h7);
    @(posedge clk_in);
    first_half_freeze_bit_in <= 1'b1;
    pins(4);
    check("clock frozen", first_half_count_out, 32'h0);
    @(posedge clk_in);
    clock_mode_freeze_override_in <= 1'b1;
    pins(4);
    check("freeze override", first_half_count_out, 32'h00000001);
    close_out();
  end
endmodule : dhtr_top_test
